// ===== ubf_core_monitor.sv
// assertion checker for the serial port buffer and interrupt block
`timescale 1ns/1ps
module ubf_core_monitor #(
    parameter int FIFO_DEPTH = 16
) (
    // clock and reset
    input wire logic       CLK_I,
    input wire logic       RESET_I,
    input wire logic       CE_I,
    // host port and gating
    input wire logic [2:0] ADDR_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic       DIVISOR_LATCH_SELECT_I,
    input wire logic       IRQ_OUTPUT_GATE_I,
    // serial and status
    input wire logic       TXD_O,
    input wire logic       TX_EMPTY_O,
    input wire logic       IRQ_O
);
    logic rd_q;
    logic rd_go;
    // a held read counts once, at its first edge
    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
            rd_q <= 1'b0;
        else if (CE_I)
            rd_q <= RD_I;
    end
    assign rd_go = CE_I && RD_I && !rd_q;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    ////////////////////////////////////////////////////////////////////////////
    property p_ier_top;
        rd_go && ADDR_I == 3'h1 && !DIVISOR_LATCH_SELECT_I |=> RDATA_O[7:4] == 4'h0;
    endproperty
    a_ier_top: assert property (p_ier_top) else $error("enable top bits set");
    property p_id_fixed;
        rd_go && ADDR_I == 3'h2 |=> RDATA_O[5:4] == 2'h0 && RDATA_O[7:6] != 2'h1;
    endproperty
    a_id_fixed: assert property (p_id_fixed) else $error("ident fixed bits");
    property p_id_code;
        rd_go && ADDR_I == 3'h2 |=> RDATA_O[3:0] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'hc};
    endproperty
    a_id_code: assert property (p_id_code) else $error("ident code unknown");
    property p_id_pend;
        rd_go && ADDR_I == 3'h2 && IRQ_OUTPUT_GATE_I |=> RDATA_O[0] == !$past(IRQ_O);
    endproperty
    a_id_pend: assert property (p_id_pend) else $error("ident pending bit");
    // data held for the whole access
    property p_frozen;
        CE_I && RD_I && rd_q |=> $stable(RDATA_O);
    endproperty
    a_frozen: assert property (p_frozen) else $error("read data moved");
    property p_gate;
        !IRQ_OUTPUT_GATE_I |-> !IRQ_O;
    endproperty
    a_gate: assert property (p_gate) else $error("request leaked");
    property p_tx_idle;
        TX_EMPTY_O |-> TXD_O;
    endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("line not idle");
    property p_tx_start;
        CE_I && WR_I && ADDR_I == 3'h0 && !DIVISOR_LATCH_SELECT_I && TX_EMPTY_O
            |-> ##[1:4] !TXD_O;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("no start bit");
    property p_dls_read;
        rd_go && DIVISOR_LATCH_SELECT_I && ADDR_I inside {3'h0, 3'h1} |=> RDATA_O == 8'h00;
    endproperty
    a_dls_read: assert property (p_dls_read) else $error("latch select read");
    // main scenarios reached
    c_ident_irq: cover property (rd_go && ADDR_I == 3'h2 && IRQ_O);
    c_tx_busy: cover property (TX_EMPTY_O ##1 !TX_EMPTY_O);
    c_gate_off: cover property (!IRQ_OUTPUT_GATE_I);
endmodule
bind ubf_uart_core ubf_core_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) ubf_core_monitor_i (.*);

// ===== ubf_pkg.sv
// constants and types shared by the serial port buffer and interrupt block
package ubf_pkg;

    // register offsets on the byte-wide host port
    localparam logic [2:0] OFS_DATA  = 3'h0;
    localparam logic [2:0] OFS_IER   = 3'h1;
    localparam logic [2:0] OFS_FIFO  = 3'h2;

    // fifo_setup field positions
    localparam int FCR_ENABLE  = 0;
    localparam int FCR_RX_CLR  = 1;
    localparam int FCR_TX_CLR  = 2;
    localparam int FCR_DMA     = 3;
    localparam int FCR_TRIG_LO = 6;
    localparam int FCR_TRIG_HI = 7;

    // irq_enable_mask field positions, and reset values for it and the trigger
    localparam int IER_DATA  = 0;
    localparam int IER_THRE  = 1;
    localparam int IER_LINE  = 2;
    localparam int IER_MODEM = 3;
    localparam logic [3:0] IER_RESET  = 4'h0;
    localparam logic [1:0] TRIG_RESET = 2'h0;

    // receive trigger levels in bytes, by code
    localparam logic [7:0] TRIG_LVL0 = 8'h01;
    localparam logic [7:0] TRIG_LVL1 = 8'h04;
    localparam logic [7:0] TRIG_LVL2 = 8'h08;
    localparam logic [7:0] TRIG_LVL3 = 8'h0e;

    // irq_source_ident codes for bits 3:0 and the fifo marker in bits 7:6
    localparam logic [3:0] ID_NONE    = 4'h1;
    localparam logic [3:0] ID_LINE    = 4'h6;
    localparam logic [3:0] ID_DATA    = 4'h4;
    localparam logic [3:0] ID_TIMEOUT = 4'hc;
    localparam logic [3:0] ID_THRE    = 4'h2;
    localparam logic [3:0] ID_MODEM   = 4'h0;
    localparam logic [1:0] ID_FIFO_ON = 2'h3;

    // serial timing in baud ticks (fixed 8 data bits, no parity, one stop)
    localparam logic [3:0] TICK_LAST    = 4'hf;
    localparam logic [3:0] SAMPLE_MID   = 4'h7;
    localparam logic [2:0] BIT_LAST     = 3'h7;
    localparam int         OVERSAMPLE   = 16;
    localparam int         CHAR_SLOTS   = 10;
    localparam int         TIMEOUT_CHARS = 4;
    localparam int         TIMEOUT_TICKS = TIMEOUT_CHARS * CHAR_SLOTS * OVERSAMPLE;

    // serial shifter states
    typedef enum logic [1:0] {
        SER_IDLE  = 2'b00,
        SER_START = 2'b01,
        SER_DATA  = 2'b10,
        SER_STOP  = 2'b11
    } ubf_ser_e;

endpackage

// ===== ubf_term_model.sv
// behavioural remote terminal on the serial line
`timescale 1ns/1ps
module ubf_term_model (
    // clock and baud tick
    input  wire logic  clk_i,
    input  wire logic  tick_i,
    // serial line and last character heard
    input  wire logic  txd_i,
    output logic       rxd_o,
    output logic [7:0] rx_byte_o,
    output int         rx_count_o
);
    // wait baud ticks, then step off the sampling edge
    task automatic ticks(input int n);
        repeat (n) @(posedge clk_i iff tick_i);
        @(negedge clk_i);
    endtask
    // one frame: start, eight bits, stop, line idles high
    task automatic send_byte(input logic [7:0] b);
        rxd_o = 1'b0;
        ticks(16);
        for (int i = 0; i < 8; i++)
        begin
            rxd_o = b[i];
            ticks(16);
        end
        rxd_o = 1'b1;
        ticks(16);
    endtask
    // listener samples near the middle of each bit
    initial
    begin
        rxd_o = 1'b1;
        rx_byte_o = 8'h00;
        rx_count_o = 0;
        forever
        begin
            @(negedge txd_i);
            ticks(8);
            for (int i = 0; i < 8; i++)
            begin
                ticks(16);
                rx_byte_o[i] = txd_i;
            end
            ticks(16);
            rx_count_o++;
        end
    end
endmodule

// ===== ubf_uart_core.sv
// serial port data buffers, fifo control and prioritised interrupt identification
`timescale 1ns/1ps
// What this block does
// [RULE1] read offset zero returns received byte
// [RULE2] serial bits travel least significant first
// [RULE3] hidden shifter assembles byte, then buffers it
// [RULE4] write offset zero loads transmit holding
// [RULE5] all enables clear: no request, ident idle
// [RULE6] enable bits: data, empty, line, modem
// [RULE7] enable bits four to seven read zero
// [RULE8] setup bit zero enables fifos, clear flushes
// [RULE9] host writes bit zero set with others
// [RULE10] setup bit one flushes receive fifo
// [RULE11] setup bit two flushes transmit fifo
// [RULE12] setup bit three ignored, four five reserved
// [RULE13] setup bits seven six pick trigger
// [RULE14] line, data/timeout, empty, modem priority order
// [RULE15] ident value frozen during host read
// [RULE16] ident bit zero low when pending
// [RULE17] ident bits three one encode source
// [RULE18] ident bit three marks timeout in fifo
// [RULE19] ident bits seven six show fifo mode
// [RULE20] four idle character times raise timeout
// [RULE21] empty interrupt cleared by ident read or write
// [RULE22] line, data, modem interrupts clear on reads
// [RULE23] host clears divisor latch select first
// [RULE24] request leaves only with output gate set
module ubf_uart_core #(
    parameter int FIFO_DEPTH = 16
) (
    // clock, reset and enable
    input  wire logic       CLK_I,
    input  wire logic       RESET_I,
    input  wire logic       CE_I,
    // host register port
    input  wire logic [2:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    // state held by the neighbouring line control and modem control logic
    input  wire logic       DIVISOR_LATCH_SELECT_I,
    input  wire logic       IRQ_OUTPUT_GATE_I,
    // events from the line status and modem status logic
    input  wire logic       LINE_ERR_I,
    input  wire logic       LINE_STATUS_RD_I,
    input  wire logic       MODEM_CHANGE_I,
    input  wire logic       MODEM_STATUS_RD_I,
    // serial line and 16x baud tick
    input  wire logic       BAUD_TICK_I,
    input  wire logic       RXD_I,
    output logic            TXD_O,
    // status towards the line status logic and the system
    output logic            DATA_READY_O,
    output logic            TX_EMPTY_O,
    output logic            OVERRUN_O,
    output logic            IRQ_O
);

    localparam int PW = $clog2(FIFO_DEPTH);
    localparam int CW = PW + 1;
    localparam int TW = $clog2(ubf_pkg::TIMEOUT_TICKS);
    localparam logic [TW-1:0] TO_LAST = TW'(ubf_pkg::TIMEOUT_TICKS - 1);

    typedef struct packed {
        logic                          rxd_meta;
        logic                          rxd_sync;
        ubf_pkg::ubf_ser_e             rx_st;
        logic [3:0]                    rx_tick;
        logic [2:0]                    rx_bit;
        logic [7:0]                    rx_shift;
        ubf_pkg::ubf_ser_e             tx_st;
        logic [3:0]                    tx_tick;
        logic [2:0]                    tx_bit;
        logic [7:0]                    tx_shift;
        logic                          txd;
        logic [1:0][7:0]               sk_data;
        logic [1:0]                    sk_cnt;
        logic [FIFO_DEPTH-1:0][7:0]    rx_mem;
        logic [PW-1:0]                 rx_wp;
        logic [PW-1:0]                 rx_rp;
        logic [CW-1:0]                 rx_cnt;
        logic [FIFO_DEPTH-1:0][7:0]    tx_mem;
        logic [PW-1:0]                 tx_wp;
        logic [PW-1:0]                 tx_rp;
        logic [CW-1:0]                 tx_cnt;
        logic [3:0]                    irq_enable_mask;
        logic                          fifo_en;
        logic [1:0]                    trig;
        logic [TW-1:0]                 to_cnt;
        logic                          to_flag;
        logic                          thre_pend;
        logic                          ls_pend;
        logic                          ms_pend;
        logic                          rd_prev;
        logic [7:0]                    rdata;
        logic                          overrun;
    } ubf_state_s;

    ubf_state_s q;
    ubf_state_s n;

    // per-cycle strobes, all but ident_now given a value at the top of the comb process
    logic          rd_start;
    logic          rx_done;
    logic          rx_pop;
    logic          rx_push;
    logic          rx_flush;
    logic          tx_push;
    logic          tx_pop;
    logic          tx_flush;
    logic          thre_clr;
    logic          thre_set;
    logic          sk_ready;
    logic [CW-1:0] cap;
    logic [3:0]    ident_now;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // trigger code to byte count
    function automatic logic [CW-1:0] trig_level(input logic [1:0] code);
        logic [7:0] lvl;
        case (code)
            2'h0:    lvl = ubf_pkg::TRIG_LVL0;
            2'h1:    lvl = ubf_pkg::TRIG_LVL1;
            2'h2:    lvl = ubf_pkg::TRIG_LVL2;
            2'h3:    lvl = ubf_pkg::TRIG_LVL3;
            default: lvl = ubf_pkg::TRIG_LVL0;
        endcase
        return lvl[CW-1:0]; // [RULE13]
    endfunction

    // highest enabled pending source; an all-clear mask reports none
    function automatic logic [3:0] ident_of(input ubf_state_s s);
        logic data_avail;
        data_avail = s.fifo_en ? (s.rx_cnt >= trig_level(s.trig)) : (s.rx_cnt != '0);
        if (s.ls_pend && s.irq_enable_mask[ubf_pkg::IER_LINE])
            return ubf_pkg::ID_LINE; // [RULE14] [RULE17] [RULE6]
        else if (data_avail && s.irq_enable_mask[ubf_pkg::IER_DATA])
            return ubf_pkg::ID_DATA; // [RULE22]
        else if (s.to_flag && s.fifo_en && s.irq_enable_mask[ubf_pkg::IER_DATA])
            return ubf_pkg::ID_TIMEOUT; // [RULE18]
        else if (s.thre_pend && s.irq_enable_mask[ubf_pkg::IER_THRE])
            return ubf_pkg::ID_THRE;
        else if (s.ms_pend && s.irq_enable_mask[ubf_pkg::IER_MODEM])
            return ubf_pkg::ID_MODEM;
        else
            return ubf_pkg::ID_NONE; // [RULE5] [RULE16]
    endfunction

    assign ident_now = ident_of(q);

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic

    always_comb
    begin
        n        = q;
        rd_start = RD_I && !q.rd_prev;
        rx_done  = 1'b0;
        rx_pop   = 1'b0;
        rx_push  = 1'b0;
        rx_flush = 1'b0;
        tx_push  = 1'b0;
        tx_pop   = 1'b0;
        tx_flush = 1'b0;
        thre_clr = 1'b0;
        thre_set = 1'b0;
        sk_ready = (q.sk_cnt != 2'h2);
        cap      = q.fifo_en ? CW'(FIFO_DEPTH) : CW'(1);
        n.overrun = 1'b0;
        n.rd_prev = RD_I;

        // the first flop only feeds the second
        n.rxd_meta = RXD_I;
        n.rxd_sync = q.rxd_meta;

        // host read: data is latched on the first cycle and held for the whole access
        if (rd_start)
        begin
            case (ADDR_I)
                ubf_pkg::OFS_DATA:
                begin
                    n.rdata = DIVISOR_LATCH_SELECT_I ? 8'h00 : q.rx_mem[q.rx_rp]; // [RULE1]
                    rx_pop  = !DIVISOR_LATCH_SELECT_I && (q.rx_cnt != '0); // [RULE22]
                end
                ubf_pkg::OFS_IER:
                    n.rdata = DIVISOR_LATCH_SELECT_I ? 8'h00 : {4'h0, q.irq_enable_mask}; // [RULE7]
                ubf_pkg::OFS_FIFO:
                begin
                    n.rdata  = {q.fifo_en ? ubf_pkg::ID_FIFO_ON : 2'h0, 2'h0, ident_now}; // [RULE15] [RULE19]
                    thre_clr = (ident_now == ubf_pkg::ID_THRE); // [RULE21]
                end
                default:
                    n.rdata = 8'h00;
            endcase
        end

        // host write; divisor latch select set routes offsets 0 and 1 elsewhere
        if (WR_I)
        begin
            case (ADDR_I)
                ubf_pkg::OFS_DATA:
                    if (!DIVISOR_LATCH_SELECT_I)
                    begin
                        tx_push  = (q.tx_cnt < cap); // [RULE4]
                        thre_clr = 1'b1; // [RULE21]
                    end
                ubf_pkg::OFS_IER:
                    if (!DIVISOR_LATCH_SELECT_I)
                    begin
                        n.irq_enable_mask    = WDATA_I[3:0]; // [RULE6] [RULE7]
                        thre_set = WDATA_I[ubf_pkg::IER_THRE] && !q.irq_enable_mask[ubf_pkg::IER_THRE]
                                   && (q.tx_cnt == '0);
                    end
                ubf_pkg::OFS_FIFO:
                begin
                    // bit 3 (dma) and bits 5:4 are dropped on purpose
                    n.fifo_en = WDATA_I[ubf_pkg::FCR_ENABLE]; // [RULE8] [RULE12]
                    if (!WDATA_I[ubf_pkg::FCR_ENABLE] || !q.fifo_en)
                    begin
                        // mode change or disable empties both fifos
                        rx_flush = 1'b1; // [RULE8]
                        tx_flush = 1'b1;
                    end
                    if (WDATA_I[ubf_pkg::FCR_ENABLE])
                    begin
                        // other fields only take effect alongside bit 0
                        n.trig = WDATA_I[ubf_pkg::FCR_TRIG_HI:ubf_pkg::FCR_TRIG_LO]; // [RULE9] [RULE13]
                        if (WDATA_I[ubf_pkg::FCR_RX_CLR])
                            rx_flush = 1'b1; // [RULE10]
                        if (WDATA_I[ubf_pkg::FCR_TX_CLR])
                            tx_flush = 1'b1; // [RULE11]
                    end
                end
                default: ;
            endcase
        end

        // receive shifter, sampled mid-bit on the 16x tick
        if (BAUD_TICK_I)
        begin
            n.rx_tick = q.rx_tick + 4'h1;
            case (q.rx_st)
                ubf_pkg::SER_IDLE:
                begin
                    n.rx_tick = 4'h0;
                    if (!q.rxd_sync)
                        n.rx_st = ubf_pkg::SER_START;
                end
                ubf_pkg::SER_START:
                    if (q.rx_tick == ubf_pkg::SAMPLE_MID)
                    begin
                        // a glitch shorter than half a bit is not a start
                        n.rx_st   = q.rxd_sync ? ubf_pkg::SER_IDLE : ubf_pkg::SER_DATA;
                        n.rx_tick = 4'h0;
                        n.rx_bit  = 3'h0;
                    end
                ubf_pkg::SER_DATA:
                    if (q.rx_tick == ubf_pkg::TICK_LAST)
                    begin
                        n.rx_shift = {q.rxd_sync, q.rx_shift[7:1]}; // [RULE2] [RULE3]
                        n.rx_bit   = q.rx_bit + 3'h1;
                        if (q.rx_bit == ubf_pkg::BIT_LAST)
                            n.rx_st = ubf_pkg::SER_STOP;
                    end
                ubf_pkg::SER_STOP:
                    if (q.rx_tick == ubf_pkg::TICK_LAST)
                    begin
                        rx_done = 1'b1; // [RULE3]
                        n.rx_st = ubf_pkg::SER_IDLE;
                    end
                default:
                    n.rx_st = ubf_pkg::SER_IDLE;
            endcase
        end

        // two-entry skid between shifter and fifo: a full fifo stalls the drain
        rx_push = (q.sk_cnt != 2'h0) && (q.rx_cnt < cap) && !rx_flush;
        if (rx_push)
        begin
            n.sk_data[0] = q.sk_data[1];
            n.sk_cnt     = q.sk_cnt - 2'h1;
        end
        if (rx_done)
        begin
            if (sk_ready)
            begin
                n.sk_data[n.sk_cnt[0]] = q.rx_shift;
                n.sk_cnt               = n.sk_cnt + 2'h1;
            end
            else
                n.overrun = 1'b1; // word lost only once the skid is also full
        end

        // receive fifo pointers
        if (rx_flush)
        begin
            n.rx_wp  = '0;
            n.rx_rp  = '0;
            n.rx_cnt = '0; // [RULE10]
        end
        else
        begin
            if (rx_push)
            begin
                n.rx_mem[q.rx_wp] = q.sk_data[0];
                n.rx_wp           = q.rx_wp + PW'(1);
            end
            if (rx_pop)
                n.rx_rp = q.rx_rp + PW'(1);
            n.rx_cnt = q.rx_cnt + CW'(rx_push) - CW'(rx_pop);
        end

        // transmit shifter reloads only when the previous byte is fully out
        tx_pop = (q.tx_st == ubf_pkg::SER_IDLE) && (q.tx_cnt != '0) && !tx_flush; // [RULE4]
        if (tx_pop)
        begin
            n.tx_shift = q.tx_mem[q.tx_rp];
            n.tx_st    = ubf_pkg::SER_START;
            n.tx_tick  = 4'h0;
            n.txd      = 1'b0;
        end
        else if (BAUD_TICK_I && (q.tx_st != ubf_pkg::SER_IDLE))
        begin
            n.tx_tick = q.tx_tick + 4'h1;
            if (q.tx_tick == ubf_pkg::TICK_LAST)
            begin
                case (q.tx_st)
                    ubf_pkg::SER_START:
                    begin
                        n.tx_st  = ubf_pkg::SER_DATA;
                        n.tx_bit = 3'h0;
                        n.txd    = q.tx_shift[0]; // [RULE2]
                    end
                    ubf_pkg::SER_DATA:
                    begin
                        n.tx_shift = {1'b0, q.tx_shift[7:1]};
                        n.tx_bit   = q.tx_bit + 3'h1;
                        if (q.tx_bit == ubf_pkg::BIT_LAST)
                        begin
                            n.tx_st = ubf_pkg::SER_STOP;
                            n.txd   = 1'b1;
                        end
                        else
                            n.txd = q.tx_shift[1]; // [RULE2]
                    end
                    ubf_pkg::SER_STOP:
                        n.tx_st = ubf_pkg::SER_IDLE;
                    default:
                        n.tx_st = ubf_pkg::SER_IDLE;
                endcase
            end
        end

        // transmit fifo pointers; a flush leaves the shifter running
        if (tx_flush)
        begin
            n.tx_wp  = '0;
            n.tx_rp  = '0;
            n.tx_cnt = '0; // [RULE11]
        end
        else
        begin
            if (tx_push)
            begin
                n.tx_mem[q.tx_wp] = WDATA_I; // [RULE4]
                n.tx_wp           = q.tx_wp + PW'(1);
            end
            if (tx_pop)
                n.tx_rp = q.tx_rp + PW'(1);
            n.tx_cnt = q.tx_cnt + CW'(tx_push) - CW'(tx_pop);
        end

        // character timeout: any traffic through the fifo restarts the wait
        if (!q.fifo_en || (q.rx_cnt == '0) || rx_push || rx_pop || rx_flush)
        begin
            n.to_cnt  = '0;
            n.to_flag = 1'b0; // [RULE20]
        end
        else if (BAUD_TICK_I && !q.to_flag)
        begin
            if (q.to_cnt == TO_LAST)
                n.to_flag = 1'b1; // [RULE20]
            else
                n.to_cnt = q.to_cnt + TW'(1);
        end

        // sticky sources; a set in the clearing cycle wins
        thre_set = thre_set || (tx_pop && (q.tx_cnt == CW'(1)) && !tx_push)
                   || (tx_flush && (q.tx_cnt != '0));
        if (thre_set)
            n.thre_pend = 1'b1;
        else if (thre_clr || tx_push)
            n.thre_pend = 1'b0; // [RULE21]
        if (LINE_ERR_I)
            n.ls_pend = 1'b1;
        else if (LINE_STATUS_RD_I)
            n.ls_pend = 1'b0; // [RULE22]
        if (MODEM_CHANGE_I)
            n.ms_pend = 1'b1;
        else if (MODEM_STATUS_RD_I)
            n.ms_pend = 1'b0; // [RULE22]
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; clock enable low freezes everything

    always_ff @(posedge CLK_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            q          <= '0;
            q.rxd_meta <= 1'b1;
            q.rxd_sync <= 1'b1;
            q.txd      <= 1'b1;
            q.irq_enable_mask      <= ubf_pkg::IER_RESET;
            q.trig     <= ubf_pkg::TRIG_RESET;
        end
        else if (CE_I)
        begin
            q <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign RDATA_O      = q.rdata;
    assign TXD_O        = q.txd;
    assign OVERRUN_O    = q.overrun;
    assign DATA_READY_O = (q.rx_cnt != '0);
    assign TX_EMPTY_O   = (q.tx_cnt == '0) && (q.tx_st == ubf_pkg::SER_IDLE);
    // request gated by the modem-control output bit
    assign IRQ_O        = IRQ_OUTPUT_GATE_I && !ident_now[0]; // [RULE24] [RULE5]

endmodule

// ===== ubf_uart_core_tb.sv
// self-checking testbench for the serial port buffer and interrupt block
`timescale 1ns/1ps
module ubf_uart_core_tb;
    logic       CLK_I, RESET_I, CE_I, WR_I, RD_I, BAUD_TICK_I, RXD_I, TXD_O;
    logic [2:0] ADDR_I;
    logic [7:0] WDATA_I, RDATA_O, rx_byte;
    logic       DIVISOR_LATCH_SELECT_I, IRQ_OUTPUT_GATE_I, LINE_ERR_I, LINE_STATUS_RD_I;
    logic       MODEM_CHANGE_I, MODEM_STATUS_RD_I, DATA_READY_O, TX_EMPTY_O, OVERRUN_O, IRQ_O;
    int         rx_count, miscompares, n_compared;
    ubf_uart_core ubf_uart_core_i (.*);
    ubf_term_model ubf_term_model_i (.clk_i(CLK_I), .tick_i(BAUD_TICK_I), .txd_i(TXD_O),
        .rxd_o(RXD_I), .rx_byte_o(rx_byte), .rx_count_o(rx_count));
    ////////////////////////////////////////////////////////////////////////////
    // 50 MHz clock; tick on every second cycle keeps frames short
    initial
    begin
        CLK_I = 1'b0;
        forever #10 CLK_I = ~CLK_I;
    end
    always @(negedge CLK_I) BAUD_TICK_I <= ~BAUD_TICK_I;
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // one write strobe, one cycle wide
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge CLK_I);
        {ADDR_I, WDATA_I, WR_I} = {a, d, 1'b1};
        @(negedge CLK_I);
        WR_I = 1'b0;
    endtask
    // read held over one edge; data is registered at that edge
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(negedge CLK_I);
        {ADDR_I, RD_I} = {a, 1'b1};
        @(negedge CLK_I);
        RD_I = 1'b0;
        check(RDATA_O, exp, what);
    endtask
    task automatic pulse(ref logic s);
        @(negedge CLK_I);
        s = 1'b1;
        @(negedge CLK_I);
        s = 1'b0;
    endtask
    task automatic complete_run;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // watchdog; tests need about 4100 cycles
    initial
    begin
        repeat (30000) @(posedge CLK_I);
        miscompares++;
        $display("wrong value at %0t: run hung", $time);
        complete_run();
    end
    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        {CE_I, WR_I, RD_I, ADDR_I, WDATA_I, BAUD_TICK_I, RESET_I} = {3'b100, 3'h0, 8'h00, 2'b01};
        {DIVISOR_LATCH_SELECT_I, IRQ_OUTPUT_GATE_I, LINE_ERR_I} = 3'b010;
        {LINE_STATUS_RD_I, MODEM_CHANGE_I, MODEM_STATUS_RD_I} = 3'b000;
        repeat (3) @(negedge CLK_I);
        RESET_I = 1'b0;
        check({7'h0, TX_EMPTY_O & TXD_O}, 8'h01, "idle");
        rd_chk(3'h1, 8'h00, "ier reset");
        rd_chk(3'h2, 8'h01, "ident reset");
        reg_wr(3'h1, 8'hf0);
        rd_chk(3'h1, 8'h00, "ier top");
        reg_wr(3'h1, 8'h0d);
        DIVISOR_LATCH_SELECT_I = 1'b1;
        rd_chk(3'h1, 8'h00, "latch sel");
        DIVISOR_LATCH_SELECT_I = 1'b0;
        rd_chk(3'h1, 8'h0d, "ier");
        $display("test registers done");
        pulse(MODEM_CHANGE_I);
        rd_chk(3'h2, 8'h00, "modem");
        pulse(LINE_ERR_I);
        rd_chk(3'h2, 8'h06, "line first");
        IRQ_OUTPUT_GATE_I = 1'b0;
        #1 check({7'h0, IRQ_O}, 8'h00, "gate");
        IRQ_OUTPUT_GATE_I = 1'b1;
        pulse(LINE_STATUS_RD_I);
        rd_chk(3'h2, 8'h00, "line cleared");
        pulse(MODEM_STATUS_RD_I);
        rd_chk(3'h2, 8'h01, "modem cleared");
        reg_wr(3'h1, 8'h02);
        rd_chk(3'h2, 8'h02, "empty");
        rd_chk(3'h2, 8'h01, "empty read");
        $display("test priority done");
        reg_wr(3'h1, 8'h00);
        reg_wr(3'h0, 8'h5a);
        reg_wr(3'h0, 8'hc3);
        for (int n = 0; n < 800 && rx_count < 1; n++) @(negedge CLK_I);
        check(rx_byte, 8'h5a, "tx first");
        for (int n = 0; n < 800 && rx_count < 2; n++) @(negedge CLK_I);
        check(rx_byte, 8'hc3, "tx second");
        $display("test transmit done");
        reg_wr(3'h1, 8'h01);
        ubf_term_model_i.send_byte(8'ha5);
        for (int n = 0; n < 100 && DATA_READY_O !== 1'b1; n++) @(negedge CLK_I);
        rd_chk(3'h2, 8'h04, "data avail");
        rd_chk(3'h0, 8'ha5, "rx byte");
        check({7'h0, DATA_READY_O}, 8'h00, "popped");
        $display("test receive done");
        reg_wr(3'h2, 8'h41);
        rd_chk(3'h2, 8'hc1, "fifo on");
        for (int k = 1; k < 4; k++) ubf_term_model_i.send_byte(8'ha0 + 8'(k));
        rd_chk(3'h2, 8'hc1, "below trigger");
        ubf_term_model_i.send_byte(8'ha4);
        repeat (4) @(negedge CLK_I);
        rd_chk(3'h2, 8'hc4, "at trigger");
        rd_chk(3'h0, 8'ha1, "fifo head");
        reg_wr(3'h2, 8'h4f);
        @(negedge CLK_I);
        check({6'h0, TX_EMPTY_O, DATA_READY_O}, 8'h02, "flush");
        ubf_term_model_i.send_byte(8'h3c);
        // idle past four character times of 320 cycles
        repeat (1400) @(negedge CLK_I);
        rd_chk(3'h2, 8'hcc, "timeout");
        rd_chk(3'h0, 8'h3c, "timeout byte");
        rd_chk(3'h2, 8'hc1, "timeout clear");
        reg_wr(3'h2, 8'h00);
        rd_chk(3'h2, 8'h01, "fifo off");
        $display("test fifo done");
        complete_run();
    end
endmodule
